//--- logic/xbpi_defs.svh
// Constants of the external bus pin interface: offsets, fields, reset values, timing.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef XBPI_DEFS_SVH
`define XBPI_DEFS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define XBPI_OFF_CTRL    8'h00
`define XBPI_OFF_ADDR    8'h04
`define XBPI_OFF_WDATA   8'h08
`define XBPI_OFF_RDATA   8'h0C
`define XBPI_OFF_STATUS  8'h10
`define XBPI_OFF_MASK    8'h14
`define XBPI_OFF_CONFIG  8'h18
`define XBPI_OFF_STATE   8'h1C
`define XBPI_OFF_WDOG    8'h20
`define XBPI_OFF_TIMERS  8'h24
`define XBPI_OFF_SERIAL  8'h28

// ----------------------------------------
// Fields
// ----------------------------------------
`define XBPI_CTRL_START   0
`define XBPI_CTRL_OP_LO   1
`define XBPI_CTRL_PORT_LO 4
`define XBPI_PORT_W       3
`define XBPI_OP_W         3
`define XBPI_EV_W         4
`define XBPI_EV_DONE      0
`define XBPI_EV_EXT       1
`define XBPI_EV_NMI       2
`define XBPI_EV_WDOG      3
`define XBPI_CFG_GIM      0
`define XBPI_CFG_SER_LO   1
`define XBPI_CFG_SER_ICLK 3
`define XBPI_CFG_T1_EXT   4
`define XBPI_CFG_T2_EXT   5
`define XBPI_CFG_WD_EN    6
`define XBPI_CFG_W        7
`define XBPI_SER_TXD      0
`define XBPI_SER_TXACT    1
`define XBPI_SER_CLK      2

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define XBPI_CFG_RST      7'h01
`define XBPI_WDOG_RST     16'hFFFF
`define XBPI_SYNC_W       23
// Device reset stays asserted until the reset pin has really been sampled
`define XBPI_SYNC_RST     23'h00_0060
`define XBPI_STROBE_CYC   4
`define XBPI_CLK_DIV      4

`endif

//--- logic/xbpi_pkg.sv
// Types shared by the external bus pin interface modules.
// Assumes xbpi_defs.svh is on the include path.
`include "xbpi_defs.svh"
package xbpi_pkg;

   // ----------------------------------------
   // Bus cycle states and operations, serial modes
   // ----------------------------------------
   typedef enum logic [2:0]
   {
      XBPI_ST_IDLE   = 3'b001,
      XBPI_ST_STROBE = 3'b010,
      XBPI_ST_DONE   = 3'b100
   } xbpi_state_t;

   typedef enum logic [2:0]
   {
      XBPI_OP_FETCH   = 3'h0,
      XBPI_OP_MEMWR   = 3'h1,
      XBPI_OP_PORTIN  = 3'h2,
      XBPI_OP_PORTOUT = 3'h3,
      XBPI_OP_PERIPH  = 3'h4
   } xbpi_op_t;

   typedef enum logic [1:0]
   {
      XBPI_SER_ASYNC = 2'h0,
      XBPI_SER_CODEC = 2'h1,
      XBPI_SER_SYNC  = 2'h2
   } xbpi_ser_t;

endpackage

//--- logic/xbpi_clkdiv.sv
// Divider that makes the system clock output from the master clock.
// Assumes the master clock is hclk and the reset is asynchronous active low.
`timescale 1ns/1ps
`default_nettype none
`include "xbpi_defs.svh"
module xbpi_clkdiv
   import xbpi_pkg::*;
(
   input  wire logic hclk,
   input  wire logic hresetn,
   output var  logic clk_out
);

   logic [1:0] div_reg;

   // ----------------------------------------
   // Divide by four, output from a flop
   // ----------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         div_reg <= 2'h0;
         clk_out <= 1'b0;
      end
      else
      begin
         div_reg <= div_reg + 2'h1;
         if (div_reg == 2'(`XBPI_CLK_DIV / 2 - 1) || div_reg == 2'(`XBPI_CLK_DIV - 1))
            clk_out <= ~clk_out;
      end
   end

   property p_clk_quarter;
      @(posedge hclk) disable iff (!hresetn)
      $rose(clk_out) |-> clk_out [*2] ##1 !clk_out [*2] ##1 clk_out;
   endproperty
   a_clk_quarter: assert property (p_clk_quarter) else $error("Clock output not one quarter");

endmodule
`default_nettype wire

//--- logic/xbpi_top.sv
// Device-side external bus pin interface with an AHB-Lite register slave.
// Assumes one clock hclk (also the master clock); pins from outside are synchronised here.
//
// The register offsets and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "xbpi_defs.svh"
module xbpi_top
   import xbpi_pkg::*;
#(
   parameter int ADDR_W = 12,
   parameter int DATA_W = 16
)
(
   input  wire logic              hclk,
   input  wire logic              hresetn,
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic              hready,
   input  wire logic [31:0]       hwdata,
   output var  logic [31:0]       hrdata,
   output wire logic              hreadyout,
   output wire logic              hresp,
   output wire logic              irq,
   output wire logic [ADDR_W-1:0] program_address_bus_o,
   output wire logic              program_address_bus_oe,
   input  wire logic [DATA_W-1:0] parallel_data_bus_i,
   output var  logic [DATA_W-1:0] parallel_data_bus_o,
   output wire logic              parallel_data_bus_oe,
   output var  logic              write_strobe_n,
   output var  logic              read_strobe_n,
   input  wire logic              ext_irq_n,
   input  wire logic              nmi_n_memory_mode_select,
   input  wire logic              reset_in_n,
   output wire logic              system_clock_out,
   input  wire logic              serial_data_i,
   output var  logic              serial_data_o,
   output var  logic              serial_data_oe,
   input  wire logic              serial_clk_i,
   output var  logic              serial_clk_o,
   output var  logic              serial_clk_oe,
   input  wire logic              timer1_or_codec_rx_clock,
   input  wire logic              timer2_or_codec_tx_clock,
   output var  logic              codec_rx_clock,
   output var  logic              codec_tx_clock,
   output var  logic              watchdog_timeout_n,
   output var  logic              fetch_external
);

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [`XBPI_SYNC_W-1:0] sync1_reg;
   logic [`XBPI_SYNC_W-1:0] sync2_reg;
   logic [DATA_W-1:0]       din_s;
   logic                    ext_s;
   logic                    nmi_s;
   logic                    rst_s;
   logic                    sdat_s;
   logic                    sclk_s;
   logic                    t1_s;
   logic                    t2_s;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sync1_reg <= `XBPI_SYNC_RST;
         sync2_reg <= `XBPI_SYNC_RST;
      end
      else
      begin
         sync1_reg <= {parallel_data_bus_i, ext_irq_n, nmi_n_memory_mode_select, reset_in_n,
                       serial_data_i, serial_clk_i, timer1_or_codec_rx_clock,
                       timer2_or_codec_tx_clock};
         sync2_reg <= sync1_reg;
      end
   end

   assign {din_s, ext_s, nmi_s, rst_s, sdat_s, sclk_s, t1_s, t2_s} = sync2_reg;

   logic dev_rst;
   assign dev_rst = ~rst_s;

   // ----------------------------------------
   // AHB-Lite slave, zero wait states
   // ----------------------------------------
   logic       wr_pend_reg;
   logic [7:0] wr_addr_reg;
   logic       acc;
   logic       wr_en;

   assign acc       = hsel & hready & htrans[1];
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign wr_en     = wr_pend_reg;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
      end
      else
      begin
         wr_pend_reg <= acc & hwrite;
         wr_addr_reg <= haddr[7:0];
      end
   end

   // ----------------------------------------
   // Software registers
   // ----------------------------------------
   logic [`XBPI_CFG_W-1:0]  cfg_reg;
   logic [DATA_W-1:0]       wdata_reg;
   logic [DATA_W-1:0]       rdata_reg;
   logic [`XBPI_EV_W-1:0]   status_reg;
   logic [`XBPI_EV_W-1:0]   mask_reg;
   logic [2:0]              ser_reg;
   xbpi_ser_t               ser_mode;
   logic                    gim;

   assign ser_mode = xbpi_ser_t'(cfg_reg[`XBPI_CFG_SER_LO +: 2]);
   assign gim      = cfg_reg[`XBPI_CFG_GIM];

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         cfg_reg   <= `XBPI_CFG_RST;
         wdata_reg <= '0;
         mask_reg  <= '0;
         ser_reg   <= 3'h0;
      end
      else if (wr_en)
      begin
         if (hit(wr_addr_reg, `XBPI_OFF_CONFIG))
            cfg_reg <= hwdata[`XBPI_CFG_W-1:0];
         if (hit(wr_addr_reg, `XBPI_OFF_WDATA))
            wdata_reg <= hwdata[DATA_W-1:0];
         if (hit(wr_addr_reg, `XBPI_OFF_MASK))
            mask_reg <= hwdata[`XBPI_EV_W-1:0];
         if (hit(wr_addr_reg, `XBPI_OFF_SERIAL))
            ser_reg <= hwdata[2:0];
      end
   end

   // ----------------------------------------
   // Reset and memory mode
   // ----------------------------------------
   logic mode_int_reg;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         mode_int_reg <= 1'b1;
      else if (dev_rst)
         mode_int_reg <= nmi_s;
   end

   assign fetch_external = ~mode_int_reg;

   // ----------------------------------------
   // Bus cycle engine
   // ----------------------------------------
   xbpi_state_t      state_reg;
   xbpi_op_t         op_reg;
   logic [2:0]       port_reg;
   logic [2:0]       cnt_reg;
   logic [ADDR_W-1:0] pc_reg;
   logic             start;
   logic             is_port;
   logic             is_write;
   logic             last;

   // Commands that arrive while busy or in reset are dropped, not queued
   assign start    = wr_en & hit(wr_addr_reg, `XBPI_OFF_CTRL) & hwdata[`XBPI_CTRL_START]
                     & (state_reg == XBPI_ST_IDLE) & ~dev_rst;
   assign is_port  = (op_reg == XBPI_OP_PORTIN) | (op_reg == XBPI_OP_PORTOUT);
   assign is_write = (op_reg == XBPI_OP_MEMWR) | (op_reg == XBPI_OP_PORTOUT);
   assign last     = (state_reg == XBPI_ST_STROBE) & (cnt_reg == 3'(`XBPI_STROBE_CYC - 1));

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state_reg <= XBPI_ST_IDLE;
         op_reg    <= XBPI_OP_FETCH;
         port_reg  <= 3'h0;
         cnt_reg   <= 3'h0;
      end
      else if (dev_rst)
      begin
         state_reg <= XBPI_ST_IDLE;
         cnt_reg   <= 3'h0;
      end
      else
      begin
         case (state_reg)
            XBPI_ST_IDLE:
            begin
               cnt_reg <= 3'h0;
               if (start)
               begin
                  op_reg    <= xbpi_op_t'(hwdata[`XBPI_CTRL_OP_LO +: `XBPI_OP_W]);
                  port_reg  <= hwdata[`XBPI_CTRL_PORT_LO +: `XBPI_PORT_W];
                  state_reg <= XBPI_ST_STROBE;
               end
            end
            XBPI_ST_STROBE:
            begin
               cnt_reg <= cnt_reg + 3'h1;
               if (last)
                  state_reg <= XBPI_ST_DONE;
            end
            XBPI_ST_DONE:
               state_reg <= XBPI_ST_IDLE;
            default:
               state_reg <= XBPI_ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         pc_reg <= '0;
      else if (dev_rst)
         pc_reg <= '0;
      else if (wr_en & hit(wr_addr_reg, `XBPI_OFF_ADDR) & (state_reg == XBPI_ST_IDLE))
         pc_reg <= hwdata[ADDR_W-1:0];
      else if (last & (op_reg == XBPI_OP_FETCH))
         pc_reg <= pc_reg + ADDR_W'(1);
   end

   // Strobes and data bus, all from flops
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         write_strobe_n      <= 1'b1;
         read_strobe_n       <= 1'b1;
         parallel_data_bus_o <= '0;
         rdata_reg           <= '0;
      end
      else
      begin
         write_strobe_n <= ~((state_reg == XBPI_ST_IDLE) & start & ~dev_rst
                           & ((hwdata[`XBPI_CTRL_OP_LO +: `XBPI_OP_W] == XBPI_OP_MEMWR)
                           | (hwdata[`XBPI_CTRL_OP_LO +: `XBPI_OP_W] == XBPI_OP_PORTOUT))
                           | (state_reg == XBPI_ST_STROBE) & ~last & is_write & ~dev_rst);
         read_strobe_n  <= ~((state_reg == XBPI_ST_IDLE) & start & ~dev_rst
                           & ((hwdata[`XBPI_CTRL_OP_LO +: `XBPI_OP_W] == XBPI_OP_FETCH)
                           | (hwdata[`XBPI_CTRL_OP_LO +: `XBPI_OP_W] == XBPI_OP_PORTIN))
                           | (state_reg == XBPI_ST_STROBE) & ~last & ~is_write
                           & (op_reg != XBPI_OP_PERIPH) & ~dev_rst);
         if (start)
            parallel_data_bus_o <= wdata_reg;
         // Data seen two cycles late through the synchroniser
         if (last & ~is_write & (op_reg != XBPI_OP_PERIPH))
            rdata_reg <= din_s;
      end
   end

   logic periph_wr;
   assign periph_wr = (state_reg == XBPI_ST_STROBE) & (op_reg == XBPI_OP_PERIPH);

   assign parallel_data_bus_oe  = ~write_strobe_n | periph_wr;
   assign program_address_bus_oe = ~dev_rst;
   assign program_address_bus_o  = (state_reg == XBPI_ST_STROBE) & is_port
                                   ? {{(ADDR_W-`XBPI_PORT_W){1'b1}}, port_reg}
                                   : pc_reg;

   // ----------------------------------------
   // Watchdog and timers
   // ----------------------------------------
   logic [15:0] wdog_reg;
   logic [15:0] t1_reg;
   logic [15:0] t2_reg;
   logic        t1_prev_reg;
   logic        t2_prev_reg;
   logic        wd_en;
   logic        wd_evt;

   assign wd_en  = cfg_reg[`XBPI_CFG_WD_EN];
   assign wd_evt = wd_en & (wdog_reg == 16'h0001)
                   & ~(wr_en & hit(wr_addr_reg, `XBPI_OFF_WDOG));

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wdog_reg           <= `XBPI_WDOG_RST;
         watchdog_timeout_n <= 1'b1;
      end
      else if (wr_en & hit(wr_addr_reg, `XBPI_OFF_WDOG))
      begin
         wdog_reg           <= hwdata[15:0];
         watchdog_timeout_n <= 1'b1;
      end
      else if (wd_en & (wdog_reg != 16'h0000))
      begin
         wdog_reg <= wdog_reg - 16'h0001;
         if (wd_evt)
            watchdog_timeout_n <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         t1_reg      <= 16'h0000;
         t2_reg      <= 16'h0000;
         t1_prev_reg <= 1'b0;
         t2_prev_reg <= 1'b0;
      end
      else
      begin
         t1_prev_reg <= t1_s;
         t2_prev_reg <= t2_s;
         if (~cfg_reg[`XBPI_CFG_T1_EXT] | (t1_s & ~t1_prev_reg))
            t1_reg <= t1_reg + 16'h0001;
         if (~cfg_reg[`XBPI_CFG_T2_EXT] | (t2_s & ~t2_prev_reg))
            t2_reg <= t2_reg + 16'h0001;
      end
   end

   // ----------------------------------------
   // Serial pin sharing
   // ----------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         serial_data_o  <= 1'b0;
         serial_data_oe <= 1'b0;
         serial_clk_o   <= 1'b1;
         serial_clk_oe  <= 1'b0;
         codec_rx_clock <= 1'b0;
         codec_tx_clock <= 1'b0;
      end
      else
      begin
         serial_data_o  <= ser_reg[`XBPI_SER_TXD];
         serial_data_oe <= (ser_mode == XBPI_SER_SYNC) & ser_reg[`XBPI_SER_TXACT];
         serial_clk_o   <= (ser_mode == XBPI_SER_SYNC) ? ser_reg[`XBPI_SER_CLK]
                                                       : ser_reg[`XBPI_SER_TXD];
         serial_clk_oe  <= (ser_mode != XBPI_SER_SYNC) | cfg_reg[`XBPI_CFG_SER_ICLK];
         codec_rx_clock <= (ser_mode == XBPI_SER_CODEC) & t1_s;
         codec_tx_clock <= (ser_mode == XBPI_SER_CODEC) & t2_s;
      end
   end

   // ----------------------------------------
   // Interrupt status, set wins over clear
   // ----------------------------------------
   logic                  nmi_prev_reg;
   logic [`XBPI_EV_W-1:0] ev;
   logic [`XBPI_EV_W-1:0] clr;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         nmi_prev_reg <= 1'b1;
      else
         nmi_prev_reg <= nmi_s;
   end

   always_comb
   begin
      ev                = '0;
      ev[`XBPI_EV_DONE] = (state_reg == XBPI_ST_DONE);
      ev[`XBPI_EV_EXT]  = ~ext_s & ~dev_rst;
      ev[`XBPI_EV_NMI]  = ~nmi_s & nmi_prev_reg & ~dev_rst;
      ev[`XBPI_EV_WDOG] = wd_evt;
   end

   assign clr = (wr_en & hit(wr_addr_reg, `XBPI_OFF_STATUS)) ? hwdata[`XBPI_EV_W-1:0] : '0;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         status_reg <= '0;
      else
         status_reg <= (status_reg & ~clr) | ev;
   end

   // Global mask gates only the maskable external request
   assign irq = |(status_reg & mask_reg & ~(`XBPI_EV_W'(gim) << `XBPI_EV_EXT));

   // ----------------------------------------
   // Read data, registered in the address phase
   // ----------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata <= 32'h0000_0000;
      else if (acc & ~hwrite)
      begin
         hrdata <= 32'h0000_0000;
         if (hit(haddr[7:0], `XBPI_OFF_ADDR))
            hrdata <= 32'(pc_reg);
         if (hit(haddr[7:0], `XBPI_OFF_WDATA))
            hrdata <= 32'(wdata_reg);
         if (hit(haddr[7:0], `XBPI_OFF_RDATA))
            hrdata <= 32'(rdata_reg);
         if (hit(haddr[7:0], `XBPI_OFF_STATUS))
            hrdata <= 32'(status_reg);
         if (hit(haddr[7:0], `XBPI_OFF_MASK))
            hrdata <= 32'(mask_reg);
         if (hit(haddr[7:0], `XBPI_OFF_CONFIG))
            hrdata <= 32'(cfg_reg);
         if (hit(haddr[7:0], `XBPI_OFF_STATE))
            hrdata <= 32'({state_reg != XBPI_ST_IDLE, dev_rst, mode_int_reg});
         if (hit(haddr[7:0], `XBPI_OFF_WDOG))
            hrdata <= 32'(wdog_reg);
         if (hit(haddr[7:0], `XBPI_OFF_TIMERS))
            hrdata <= {t2_reg, t1_reg};
         if (hit(haddr[7:0], `XBPI_OFF_SERIAL))
            hrdata <= 32'({sclk_s, sdat_s});
      end
   end

   xbpi_clkdiv u_clkdiv
   (
      .hclk    (hclk),
      .hresetn (hresetn),
      .clk_out (system_clock_out)
   );

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   property p_addr_oe;
      $past(hresetn, 2) |-> program_address_bus_oe == $past(reset_in_n, 2);
   endproperty
   a_addr_oe: assert property (p_addr_oe) else $error("Address drive wrong vs reset");

   property p_port_addr;
      (state_reg == XBPI_ST_STROBE) && is_port
         |-> program_address_bus_o[2:0] == port_reg && &program_address_bus_o[ADDR_W-1:3];
   endproperty
   a_port_addr: assert property (p_port_addr) else $error("Port address lines wrong");

   property p_data_oe;
      parallel_data_bus_oe |-> state_reg == XBPI_ST_STROBE && op_reg != XBPI_OP_FETCH
                               && op_reg != XBPI_OP_PORTIN;
   endproperty
   a_data_oe: assert property (p_data_oe) else $error("Data bus driven without cause");

   property p_wr_strobe;
      $fell(write_strobe_n) |-> (!write_strobe_n && parallel_data_bus_oe) [*4] ##1 write_strobe_n;
   endproperty
   a_wr_strobe: assert property (p_wr_strobe) else $error("Write strobe not four cycles");

   property p_rd_strobe;
      !read_strobe_n |-> !parallel_data_bus_oe && write_strobe_n;
   endproperty
   a_rd_strobe: assert property (p_rd_strobe) else $error("Read strobe with bus driven");

   property p_pc_reset;
      dev_rst |=> pc_reg == '0 && state_reg == XBPI_ST_IDLE;
   endproperty
   a_pc_reset: assert property (p_pc_reset) else $error("Counter not zero in reset");

   property p_ext_irq;
      !ext_s && !dev_rst |=> status_reg[`XBPI_EV_EXT];
   endproperty
   a_ext_irq: assert property (p_ext_irq) else $error("External request not seen");

   property p_nmi;
      $fell(nmi_s) && !dev_rst && mask_reg[`XBPI_EV_NMI] && gim |=> irq;
   endproperty
   a_nmi: assert property (p_nmi) else $error("NMI blocked by global mask");

   property p_mode;
      dev_rst |=> mode_int_reg == $past(nmi_s);
   endproperty
   a_mode: assert property (p_mode) else $error("Mode not sampled in reset");

   property p_wdog;
      wd_evt |=> !watchdog_timeout_n;
   endproperty
   a_wdog: assert property (p_wdog) else $error("Watchdog output not low");

   c_write:  cover property ($fell(write_strobe_n));
   c_portin: cover property (!read_strobe_n && is_port);
   c_nmi:    cover property (status_reg[`XBPI_EV_NMI] && irq);
   c_wdog:   cover property ($fell(watchdog_timeout_n));

endmodule
`default_nettype wire

//--- tb/xbpi_mem_model.sv
// Far-side program memory and port peripheral model.
// Assumes active-low read strobe from the device and the one clock hclk.
`timescale 1ns/1ps
`default_nettype none
module xbpi_mem_model
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        read_strobe_n,
   output var  logic [15:0] mem_data
);
   // Released bus toggles, so after a read a stale value matches A5C3 only on every other cycle
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         mem_data <= 16'h0000;
      else if (!read_strobe_n)
         mem_data <= 16'hA5C3;
      else
         mem_data <= ~mem_data;
   end
endmodule
`default_nettype wire

//--- tb/test_external_bus_pin_interface.sv
// Testbench of the external bus pin interface: AHB-Lite master, pins, model.
// Assumes the design package, defaults and a 40 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module test_external_bus_pin_interface;
   import xbpi_pkg::*;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, irq, ext_irq_n, reset_in_n;
   logic nmi_n_memory_mode_select, write_strobe_n, read_strobe_n, system_clock_out;
   logic program_address_bus_oe, parallel_data_bus_oe, watchdog_timeout_n, fetch_external;
   logic serial_data_o, serial_data_oe, serial_clk_o, serial_clk_oe, codec_rx_clock, t1_pin;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata, r;
   logic [11:0] program_address_bus_o;
   logic [15:0] parallel_data_bus_i, parallel_data_bus_o, mem_data;
   int err_count, n_compared, cyc, k;
   assign hready = hreadyout;
   assign parallel_data_bus_i = parallel_data_bus_oe ? parallel_data_bus_o : mem_data;
   xbpi_top dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hready,
      .hwdata, .hrdata, .hreadyout, .hresp(), .irq, .program_address_bus_o,
      .program_address_bus_oe, .parallel_data_bus_i, .parallel_data_bus_o,
      .parallel_data_bus_oe, .write_strobe_n, .read_strobe_n, .ext_irq_n,
      .nmi_n_memory_mode_select, .reset_in_n, .system_clock_out, .serial_data_i(1'b0),
      .serial_data_o, .serial_data_oe, .serial_clk_i(1'b0), .serial_clk_o, .serial_clk_oe,
      .timer1_or_codec_rx_clock(t1_pin), .timer2_or_codec_tx_clock(1'b0), .codec_rx_clock,
      .codec_tx_clock(), .watchdog_timeout_n, .fetch_external);
   xbpi_mem_model mem_u (.hclk, .hresetn, .read_strobe_n, .mem_data);
   initial
   begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         err_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1; htrans <= 2'b10; hwrite <= w; haddr <= {24'h0000_00, a};
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      r = hrdata;
   endtask
   task automatic pin_wait(input logic [31:0] ctl);
      bus(1'b1, 8'h00, ctl);
      for (k = 0; k < 3; k++) @(posedge hclk);
      @(negedge hclk);
   endtask
   task automatic stop_test;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Whole run is a few hundred cycles, so this only catches a hang
   always @(posedge hclk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         err_count++;
         stop_test();
      end
   end
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_port_out;
      bus(1'b1, 8'h08, 32'h0000_1234);
      pin_wait(32'h0000_0057);
      chk(program_address_bus_o, 12'hFFD);
      chk({write_strobe_n, parallel_data_bus_oe}, 2'b01);
      chk(parallel_data_bus_o, 16'h1234);
      repeat (6) @(posedge hclk);
      chk({write_strobe_n, parallel_data_bus_oe}, 2'b10);
   endtask
   task automatic t_fetch_periph;
      bus(1'b1, 8'h04, 32'h0000_0010);
      pin_wait(32'h0000_0001);
      chk({read_strobe_n, parallel_data_bus_oe, program_address_bus_o}, 14'h0010);
      repeat (6) @(posedge hclk);
      bus(1'b0, 8'h0C, 32'h0);
      chk(r, 32'h0000_A5C3);
      pin_wait(32'h0000_0009);
      chk({write_strobe_n, parallel_data_bus_oe}, 2'b11);
      repeat (6) @(posedge hclk);
   endtask
   task automatic t_irq;
      bus(1'b1, 8'h14, 32'h0000_000F);
      bus(1'b1, 8'h18, 32'h0000_0000);
      bus(1'b1, 8'h10, 32'h0000_000F);
      ext_irq_n <= 1'b0;
      repeat (4) @(posedge hclk);
      ext_irq_n <= 1'b1;
      repeat (4) @(posedge hclk);
      bus(1'b0, 8'h10, 32'h0);
      chk({irq, r[1]}, 2'b11);
      bus(1'b1, 8'h18, 32'h0000_0001);
      bus(1'b1, 8'h10, 32'h0000_000F);
      @(negedge hclk);
      chk(irq, 1'b0);
      ext_irq_n <= 1'b0;
      repeat (4) @(posedge hclk);
      ext_irq_n <= 1'b1;
      repeat (4) @(posedge hclk);
      bus(1'b0, 8'h10, 32'h0);
      chk({irq, r[1]}, 2'b01);
      bus(1'b1, 8'h10, 32'h0000_000F);
      nmi_n_memory_mode_select <= 1'b0;
      repeat (4) @(posedge hclk);
      nmi_n_memory_mode_select <= 1'b1;
      repeat (4) @(posedge hclk);
      bus(1'b0, 8'h10, 32'h0);
      chk({irq, r[2]}, 2'b11);
      bus(1'b1, 8'h10, 32'h0000_000F);
   endtask
   task automatic t_wdog;
      bus(1'b1, 8'h20, 32'h0000_0003);
      bus(1'b1, 8'h18, 32'h0000_0041);
      chk(watchdog_timeout_n, 1'b1);
      repeat (6) @(posedge hclk);
      bus(1'b0, 8'h10, 32'h0);
      chk({watchdog_timeout_n, r[3]}, 2'b01);
      bus(1'b1, 8'h18, 32'h0000_0001);
      bus(1'b1, 8'h20, 32'h0000_FFFF);
      @(negedge hclk);
      chk(watchdog_timeout_n, 1'b1);
   endtask
   task automatic t_serial;
      bus(1'b1, 8'h18, 32'h0000_000D);
      bus(1'b1, 8'h28, 32'h0000_0007);
      repeat (2) @(negedge hclk);
      chk({serial_data_oe, serial_data_o, serial_clk_oe, serial_clk_o}, 4'hF);
      bus(1'b1, 8'h18, 32'h0000_0003);
      t1_pin <= 1'b1;
      repeat (4) @(posedge hclk);
      chk({serial_data_oe, serial_clk_oe, serial_clk_o, codec_rx_clock}, 4'h7);
      t1_pin <= 1'b0;
   endtask
   task automatic t_clk_mode;
      k = 0;
      repeat (40)
      begin
         @(posedge system_clock_out or posedge hclk);
      end
      for (int i = 0; i < 40; i++)
      begin
         @(negedge hclk);
         r[0] = system_clock_out;
         @(posedge hclk);
         #1 k += (system_clock_out & ~r[0]);
      end
      chk(k, 10);
      reset_in_n <= 1'b0;
      nmi_n_memory_mode_select <= 1'b0;
      repeat (6) @(posedge hclk);
      chk(program_address_bus_oe, 1'b0);
      reset_in_n <= 1'b1;
      repeat (4) @(posedge hclk);
      nmi_n_memory_mode_select <= 1'b1;
      @(negedge hclk);
      chk({program_address_bus_oe, fetch_external, program_address_bus_o}, 14'h3000);
   endtask
   initial
   begin
      {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
      {t1_pin, ext_irq_n, reset_in_n, nmi_n_memory_mode_select} = 4'b0111;
      repeat (4) @(posedge hclk);
      chk(program_address_bus_oe, 1'b0);
      hresetn <= 1'b1;
      repeat (3) @(posedge hclk);
      chk({program_address_bus_oe, program_address_bus_o}, 13'h1000);
      t_port_out();
      t_fetch_periph();
      t_irq();
      t_wdog();
      t_serial();
      t_clk_mode();
      stop_test();
   end
endmodule
`default_nettype wire
